// *** design/sample_fifo.sv ***
`timescale 1ns/1ps

module sample_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_wr_valid,
	input wire logic [WIDTH-1:0] i_wr_data,
	output logic o_wr_ready,
	output logic o_rd_valid,
	output logic [WIDTH-1:0] o_rd_data,
	input wire logic i_rd_ready
);
	localparam int CW = $clog2(DEPTH + 1);

	if (DEPTH < 2 || WIDTH < 1) begin : g_bad_params
		$error("sample_fifo needs DEPTH >= 2 and WIDTH >= 1");
	end

	// ----------------------------------------
	// Shift-down storage
	// ----------------------------------------
	// Head always sits in slot 0, so read data come straight from a register
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] data;
		logic [CW-1:0] count;
		logic ready;
	} fifo_state_s;

	fifo_state_s q, d;
	logic push, pop;
	logic [CW-1:0] slot;

	always_comb begin
		d = q;
		pop = (q.count != '0) && i_rd_ready;
		push = i_wr_valid && q.ready;
		if (pop) begin
			for (int k = 0; k < DEPTH - 1; k++) begin
				d.data[k] = q.data[k + 1];
			end
		end
		slot = pop ? q.count - CW'(1) : q.count;
		if (push) begin
			d.data[slot] = i_wr_data;
		end
		d.count = q.count + CW'(push) - CW'(pop);
		d.ready = d.count < CW'(DEPTH);
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_wr_ready = q.ready;
	assign o_rd_valid = q.count != '0;
	assign o_rd_data = q.data[0];

endmodule : sample_fifo

// *** design/tx_datapath_config.sv ***
`timescale 1ns/1ps

// Overview of operation
// - Inverse sinc bypass bit 6 skips that filter; bits 7,6,5 reset to one.
// - Oscillator gain bit 3 halves the oscillator amplitude; zero means no scaling.
// - Phase compensation bypass bit 2, reset one, skips phase and dc offset stage.
// - Sideband bit 1 zero gives high-side image, one gives low-side image.
// - Low-side image output spectrum is inverted relative to input data.
// - Copy bit 0 drops input Q, freezes Q path, drives both outputs from I.
// - First stage mode 00 gives an unmodulated passband.
// - First stage modes 01, 10 and 11 modulate by one, two or three quarter turns per sample.
// - First stage bypass bit 0 skips the first half-band; default zero.
// - Second stage mode bits 6:1 default zero; only code 0 in bits 6:4 gives an unmodulated passband.
// - Second stage codes 1..7 modulate by that many eighth turns per sample.
// - Second stage bypass bit 0 skips the second half-band; default zero.
// - Fields are read and written over the four-wire serial port.

module tx_datapath_config
	import tx_datapath_pkg::*;
#(
	parameter logic signed [SAMPLE_W-1:0] DC_OFFSET_I = 16'sh0000,
	parameter logic signed [SAMPLE_W-1:0] DC_OFFSET_Q = 16'sh0000,
	parameter logic signed [7:0] PHASE_ADJUST = 8'sh00
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_spi_clk,
	input wire logic i_spi_cs_n,
	input wire logic i_spi_mosi,
	output logic o_spi_miso,
	output logic o_spi_miso_oe,
	input wire logic i_in_valid,
	input wire logic [SAMPLE_W-1:0] i_in_i,
	input wire logic [SAMPLE_W-1:0] i_in_q,
	output logic o_in_ready,
	input wire logic i_dac_take,
	output logic o_dac_valid,
	output logic [SAMPLE_W-1:0] o_dac_i,
	output logic [SAMPLE_W-1:0] o_dac_q
);

	// ----------------------------------------
	// Arithmetic helpers
	// ----------------------------------------
	function automatic logic [SAMPLE_W-1:0] sat16(input logic signed [WORK_W-1:0] v);
		logic signed [WORK_W-1:0] hi;
		hi = WORK_W'(16'sh7fff);
		if (v > hi) return 16'h7fff;
		else if (v < -hi - WORK_W'(1)) return 16'h8000;
		else return v[SAMPLE_W-1:0];
	endfunction : sat16

	function automatic iq_s rot_quarter(input iq_s x, input logic [1:0] k);
		iq_s r;
		r = x;
		case (k)
			2'h1: r = '{i: -x.q, q: x.i};
			2'h2: r = '{i: -x.i, q: -x.q};
			2'h3: r = '{i: x.q, q: -x.i};
			default: r = x;
		endcase
		return r;
	endfunction : rot_quarter

	function automatic iq_s rot_eighth(input iq_s x, input logic [2:0] k);
		iq_s r;
		logic signed [WORK_W+9:0] pi, pq;
		r = rot_quarter(x, k[2:1]);
		pi = (WORK_W+10)'(r.i - r.q) * COS45_Q8;
		pq = (WORK_W+10)'(r.i + r.q) * COS45_Q8;
		if (k[0]) r = '{i: pi[WORK_W+7:8], q: pq[WORK_W+7:8]};
		return r;
	endfunction : rot_eighth

	function automatic iq_s avg2(input iq_s a, input iq_s b);
		logic signed [WORK_W:0] si, sq;
		si = (WORK_W+1)'(a.i) + (WORK_W+1)'(b.i);
		sq = (WORK_W+1)'(a.q) + (WORK_W+1)'(b.q);
		return '{i: si[WORK_W:1], q: sq[WORK_W:1]};
	endfunction : avg2

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic cs_m, cs_s, clk_m, clk_s, clk_prev, mosi_m, mosi_s;
		logic [4:0] bit_cnt;
		logic [14:0] shift_in;
		logic [6:0] addr;
		logic rd;
		logic [7:0] shift_out;
		logic miso, miso_oe;
		logic [7:0] datapath_control, first_halfband_control, second_halfband_control;
		logic [1:0] hb1_acc;
		logic premod_ph;
		logic [2:0] hb2_acc;
		logic [1:0] osc_ph;
		iq_s hb1_prev, hb2_prev, sinc_p1, sinc_p2;
		logic dac_valid;
		logic [SAMPLE_W-1:0] dac_i, dac_q;
	} core_state_s;

	core_state_s q, d;

	logic fifo_valid;
	logic [2*SAMPLE_W-1:0] fifo_data;
	logic pop, rise, fall, wr_commit;
	logic [7:0] frame_byte;
	logic [7:0] dp;
	logic [FIRST_MODE_W-1:0] first_halfband_mode;
	logic [SECOND_MODE_W-1:0] second_halfband_mode;
	iq_s s_in, s_hb1, s_pre, s_hb2, s_osc, s_ph, s_out;
	logic signed [WORK_W+7:0] ph_prod;

	// ----------------------------------------
	// Input buffer
	// ----------------------------------------
	// Drained only on converter ticks, so a fast source fills it and stalls
	sample_fifo #(
		.WIDTH(2 * SAMPLE_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_wr_valid(i_in_valid),
		.i_wr_data({i_in_i, i_in_q}),
		.o_wr_ready(o_in_ready),
		.o_rd_valid(fifo_valid),
		.o_rd_data(fifo_data),
		.i_rd_ready(i_dac_take)
	);

	function automatic logic [7:0] reg_read(input core_state_s s, input logic [6:0] a);
		if (a == ADDR_DATAPATH_CONTROL) return s.datapath_control;
		else if (a == ADDR_FIRST_HALFBAND_CONTROL) return s.first_halfband_control;
		else if (a == ADDR_SECOND_HALFBAND_CONTROL) return s.second_halfband_control;
		else return 8'h00;
	endfunction : reg_read

	always_comb begin
		d = q;
		// ----------------------------------------
		// Serial port, sampled through two flops
		// ----------------------------------------
		d.cs_m = i_spi_cs_n;
		d.cs_s = q.cs_m;
		d.clk_m = i_spi_clk;
		d.clk_s = q.clk_m;
		d.clk_prev = q.clk_s;
		d.mosi_m = i_spi_mosi;
		d.mosi_s = q.mosi_m;
		rise = q.clk_s && !q.clk_prev;
		fall = !q.clk_s && q.clk_prev;
		frame_byte = {q.shift_in[6:0], q.mosi_s};
		wr_commit = 1'b0;
		if (q.cs_s) begin
			d.bit_cnt = '0;
			d.rd = 1'b0;
			d.miso_oe = 1'b0;
		end else if (rise && q.bit_cnt < SPI_FRAME_BITS) begin
			d.shift_in = {q.shift_in[13:0], q.mosi_s};
			d.bit_cnt = q.bit_cnt + 5'h01;
			if (q.bit_cnt == SPI_INSTR_LAST) begin
				d.addr = frame_byte[6:0];
				d.rd = frame_byte[SPI_READ_FLAG];
				d.shift_out = reg_read(q, frame_byte[6:0]);
			end else if (q.bit_cnt == SPI_FRAME_LAST && !q.rd) begin
				wr_commit = 1'b1;
				if (q.addr == ADDR_DATAPATH_CONTROL) begin
					d.datapath_control = frame_byte & DATAPATH_CONTROL_MASK;
				end else if (q.addr == ADDR_FIRST_HALFBAND_CONTROL) begin
					d.first_halfband_control = frame_byte & FIRST_HALFBAND_CONTROL_MASK;
				end else if (q.addr == ADDR_SECOND_HALFBAND_CONTROL) begin
					d.second_halfband_control = frame_byte & SECOND_HALFBAND_CONTROL_MASK;
				end
			end
		end else if (fall && q.rd && q.bit_cnt > SPI_INSTR_LAST) begin
			d.miso = q.shift_out[7];
			d.shift_out = {q.shift_out[6:0], 1'b0};
			d.miso_oe = q.bit_cnt < SPI_FRAME_BITS;
		end

		// ----------------------------------------
		// Datapath chain
		// ----------------------------------------
		dp = q.datapath_control;
		first_halfband_mode = q.first_halfband_control[FIRST_MODE_LSB +: FIRST_MODE_W];
		second_halfband_mode = q.second_halfband_control[SECOND_MODE_LSB +: SECOND_MODE_W];
		pop = fifo_valid && i_dac_take;
		s_in.i = WORK_W'($signed(fifo_data[2*SAMPLE_W-1:SAMPLE_W]));
		s_in.q = dp[BIT_I_TO_Q_COPY] ? '0 : WORK_W'($signed(fifo_data[SAMPLE_W-1:0]));
		// Mode rotates by its code every output sample, then a two-tap smoother
		s_hb1 = q.first_halfband_control[BIT_STAGE_BYPASS] ? s_in
			: avg2(rot_quarter(s_in, q.hb1_acc), q.hb1_prev);
		s_pre = (dp[BIT_PREMOD_BYPASS] || !q.premod_ph) ? s_hb1 : iq_s'{i: -s_hb1.i, q: -s_hb1.q};
		s_hb2 = q.second_halfband_control[BIT_STAGE_BYPASS] ? s_pre
			: avg2(rot_eighth(s_pre, q.hb2_acc), q.hb2_prev);
		// Quarter-rate carrier; low side conjugates, which inverts the spectrum
		s_osc = s_hb2;
		if (!dp[BIT_OSCILLATOR_BYPASS]) begin
			s_osc = dp[BIT_SIDEBAND_LOW] ? iq_s'{i: s_hb2.i, q: -s_hb2.q} : s_hb2;
			s_osc = rot_quarter(s_osc, q.osc_ph);
			if (dp[BIT_OSCILLATOR_GAIN_SCALE]) begin
				s_osc = '{i: s_osc.i >>> 1, q: s_osc.q >>> 1};
			end
		end
		ph_prod = (WORK_W+8)'(s_osc.i) * PHASE_ADJUST;
		s_ph = s_osc;
		if (!dp[BIT_PHASE_BYPASS]) begin
			s_ph.i = s_osc.i + WORK_W'(DC_OFFSET_I);
			s_ph.q = s_osc.q + ph_prod[WORK_W+7:8] + WORK_W'(DC_OFFSET_Q);
		end
		// Sharpening three-tap on the previous sample; costs one sample of delay
		s_out = dp[BIT_SINC_BYPASS] ? s_ph : iq_s'{
			i: q.sinc_p1.i + ((q.sinc_p1.i + q.sinc_p1.i - s_ph.i - q.sinc_p2.i) >>> 4),
			q: q.sinc_p1.q + ((q.sinc_p1.q + q.sinc_p1.q - s_ph.q - q.sinc_p2.q) >>> 4)};

		d.dac_valid = pop;
		if (pop) begin
			d.hb1_acc = q.hb1_acc + first_halfband_mode;
			d.hb2_acc = q.hb2_acc + second_halfband_mode[5:3];
			d.premod_ph = !q.premod_ph;
			d.osc_ph = q.osc_ph + 2'h1;
			d.hb1_prev = rot_quarter(s_in, q.hb1_acc);
			d.hb2_prev = rot_eighth(s_pre, q.hb2_acc);
			d.sinc_p2 = q.sinc_p1;
			d.sinc_p1 = s_ph;
			d.dac_i = sat16(s_out.i);
			d.dac_q = dp[BIT_I_TO_Q_COPY] ? sat16(s_out.i) : sat16(s_out.q);
			// Q history frozen while copying, standing in for the gated Q clocks
			if (dp[BIT_I_TO_Q_COPY]) begin
				d.hb1_prev.q = q.hb1_prev.q;
				d.hb2_prev.q = q.hb2_prev.q;
				d.sinc_p1.q = q.sinc_p1.q;
				d.sinc_p2.q = q.sinc_p2.q;
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q <= '0;
			q.cs_m <= 1'b1;
			q.cs_s <= 1'b1;
			q.datapath_control <= DATAPATH_CONTROL_RST;
			q.first_halfband_control <= FIRST_HALFBAND_CONTROL_RST;
			q.second_halfband_control <= SECOND_HALFBAND_CONTROL_RST;
		end else begin
			q <= d;
		end
	end

	assign o_spi_miso = q.miso;
	assign o_spi_miso_oe = q.miso_oe;
	assign o_dac_valid = q.dac_valid;
	assign o_dac_i = q.dac_i;
	assign o_dac_q = q.dac_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	logic only_osc, all_bypass;
	assign all_bypass = dp[BIT_PREMOD_BYPASS] && dp[BIT_SINC_BYPASS] && dp[BIT_OSCILLATOR_BYPASS]
		&& dp[BIT_PHASE_BYPASS] && q.first_halfband_control[0] && q.second_halfband_control[0];
	assign only_osc = dp[BIT_PREMOD_BYPASS] && dp[BIT_SINC_BYPASS] && !dp[BIT_OSCILLATOR_BYPASS]
		&& dp[BIT_PHASE_BYPASS] && q.first_halfband_control[0] && q.second_halfband_control[0]
		&& !dp[BIT_I_TO_Q_COPY] && q.osc_ph == 2'h0;

	sequence seq_frame_write(logic [6:0] a);
		wr_commit && q.addr == a;
	endsequence

	sequence seq_sample_taken;
		pop ##1 o_dac_valid;
	endsequence

	a_reset_defaults: assert property (!$past(i_rst_n) |-> q.datapath_control == DATAPATH_CONTROL_RST
		&& q.first_halfband_control == '0 && q.second_halfband_control == '0)
		else $error("register defaults wrong after reset");
	a_sinc_skip: assert property (pop && dp[BIT_SINC_BYPASS] |=> o_dac_i == $past(sat16(s_ph.i)))
		else $error("inverse sinc not bypassed");
	a_full_bypass: assert property (pop && all_bypass && !dp[BIT_I_TO_Q_COPY]
		|=> o_dac_i == $past(fifo_data[31:16]) && o_dac_q == $past(fifo_data[15:0]))
		else $error("bypassed stages altered the sample");
	a_gain_half: assert property (pop && only_osc && dp[BIT_OSCILLATOR_GAIN_SCALE]
		&& !dp[BIT_SIDEBAND_LOW] |=> o_dac_i == $past(sat16(s_in.i >>> 1)))
		else $error("oscillator gain scaling wrong");
	a_dc_offset: assert property (pop && !dp[BIT_PHASE_BYPASS] && dp[BIT_SINC_BYPASS]
		|=> o_dac_i == $past(sat16(s_osc.i + WORK_W'(DC_OFFSET_I))))
		else $error("phase stage not applied");
	a_low_side: assert property (pop && only_osc && !dp[BIT_OSCILLATOR_GAIN_SCALE]
		&& dp[BIT_SIDEBAND_LOW] |=> o_dac_q == $past(sat16(-s_in.q)))
		else $error("low side image not inverted");
	a_copy_q: assert property (pop && dp[BIT_I_TO_Q_COPY] |=> o_dac_q == o_dac_i
		&& q.sinc_p1.q == $past(q.sinc_p1.q))
		else $error("Q path not driven from I");
	a_first_mode: assert property (pop && !q.first_halfband_control[0]
		|=> q.hb1_acc == $past(q.hb1_acc + first_halfband_mode))
		else $error("first stage modulation phase wrong");
	a_second_mode: assert property (pop && !q.second_halfband_control[0]
		|=> q.hb2_acc == $past(q.hb2_acc + second_halfband_mode[5:3]))
		else $error("second stage modulation phase wrong");
	a_stage_bypass: assert property (seq_sample_taken and (pop && q.first_halfband_control[0]
		&& q.second_halfband_control[0] ##1 1'b1) |-> $past(s_hb1 == s_in && s_hb2 == s_pre))
		else $error("half-band bypass path wrong");
	a_reg_write: assert property (seq_frame_write(ADDR_DATAPATH_CONTROL)
		|=> q.datapath_control == $past(frame_byte & DATAPATH_CONTROL_MASK))
		else $error("serial write not stored");
	a_miso_quiet: assert property (q.cs_s |=> !o_spi_miso_oe)
		else $error("data out driven while deselected");

endmodule : tx_datapath_config

// *** design/tx_datapath_pkg.sv ***
package tx_datapath_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [6:0] ADDR_DATAPATH_CONTROL = 7'h1b;
	localparam logic [6:0] ADDR_FIRST_HALFBAND_CONTROL = 7'h1c;
	localparam logic [6:0] ADDR_SECOND_HALFBAND_CONTROL = 7'h1d;

	localparam logic [7:0] DATAPATH_CONTROL_RST = 8'he4;
	localparam logic [7:0] FIRST_HALFBAND_CONTROL_RST = 8'h00;
	localparam logic [7:0] SECOND_HALFBAND_CONTROL_RST = 8'h00;

	// Reserved bits read back as zero
	localparam logic [7:0] DATAPATH_CONTROL_MASK = 8'hef;
	localparam logic [7:0] FIRST_HALFBAND_CONTROL_MASK = 8'h07;
	localparam logic [7:0] SECOND_HALFBAND_CONTROL_MASK = 8'h7f;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_PREMOD_BYPASS = 7;
	localparam int BIT_SINC_BYPASS = 6;
	localparam int BIT_OSCILLATOR_BYPASS = 5;
	localparam int BIT_OSCILLATOR_GAIN_SCALE = 3;
	localparam int BIT_PHASE_BYPASS = 2;
	localparam int BIT_SIDEBAND_LOW = 1;
	localparam int BIT_I_TO_Q_COPY = 0;
	localparam int BIT_STAGE_BYPASS = 0;
	localparam int FIRST_MODE_LSB = 1;
	localparam int FIRST_MODE_W = 2;
	localparam int SECOND_MODE_LSB = 1;
	localparam int SECOND_MODE_W = 6;

	// ----------------------------------------
	// Serial port framing
	// ----------------------------------------
	localparam logic [4:0] SPI_INSTR_LAST = 5'h07;
	localparam logic [4:0] SPI_FRAME_LAST = 5'h0f;
	localparam logic [4:0] SPI_FRAME_BITS = 5'h10;
	localparam int SPI_READ_FLAG = 7;

	// ----------------------------------------
	// Datapath
	// ----------------------------------------
	localparam int SAMPLE_W = 16;
	localparam int WORK_W = 20;
	localparam int FIFO_DEPTH = 4;
	localparam logic signed [9:0] COS45_Q8 = 10'sh0b5;

	typedef struct packed {
		logic signed [WORK_W-1:0] i;
		logic signed [WORK_W-1:0] q;
	} iq_s;

endpackage : tx_datapath_pkg

// *** verification/spi_host_model.sv ***
`timescale 1ns/1ps

module spi_host_model (
	input wire logic i_clk_sys,
	output logic o_spi_clk,
	output logic o_spi_cs_n,
	output logic o_spi_mosi,
	input wire logic i_spi_miso,
	input wire logic i_spi_miso_oe
);
	// Slow serial clock: each phase must span at least 3 system clocks
	localparam int HALF = 6;
	logic miso_line;

	// Undriven line reads inverted, so a late enable shows up as bad data
	assign miso_line = i_spi_miso_oe ? i_spi_miso : ~i_spi_miso;

	initial begin
		o_spi_clk = 1'b0;
		o_spi_cs_n = 1'b1;
		o_spi_mosi = 1'b0;
	end

	// ----------------------------------------
	// One frame, mode 0, MSB first
	// ----------------------------------------
	// Clock rests low between frames; data line flips once deselected
	task automatic xfer(input logic [15:0] frame, output logic [7:0] rdata, output logic oe_ok);
		oe_ok = 1'b1;
		rdata = 8'h00;
		@(negedge i_clk_sys);
		o_spi_cs_n = 1'b0;
		for (int b = 15; b >= 0; b--) begin
			o_spi_mosi = frame[b];
			repeat (HALF) @(negedge i_clk_sys);
			if (b < 8) begin
				rdata = {rdata[6:0], miso_line};
				oe_ok = oe_ok & (i_spi_miso_oe === 1'b1);
			end
			o_spi_clk = 1'b1;
			repeat (HALF) @(negedge i_clk_sys);
			o_spi_clk = 1'b0;
		end
		repeat (HALF) @(negedge i_clk_sys);
		o_spi_cs_n = 1'b1;
		o_spi_mosi = ~o_spi_mosi;
		repeat (8) @(negedge i_clk_sys);
	endtask : xfer
endmodule : spi_host_model

// *** verification/tx_datapath_config_test.sv ***
`timescale 1ns/1ps

module tx_datapath_config_test;
	import tx_datapath_pkg::*;

	localparam int LIMIT = 40000;
	logic clk;
	logic rst_n;
	logic spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
	logic in_valid, in_ready, dac_take, dac_valid;
	logic [15:0] in_i, in_q, dac_i, dac_q;
	logic [7:0] rd;
	logic ok;
	logic seen;
	int fails = 0;
	int total_checks = 0;
	int cycles = 0;
	// Address, written value, value read back
	logic [23:0] rows [21] = '{
		24'h1bffef, 24'h1b0808, 24'h1b0202, 24'h1be4e4,
		24'h1cff07, 24'h1c0000, 24'h1c0202, 24'h1c0404, 24'h1c0606, 24'h1c0101,
		24'h1dff7f, 24'h1d0000, 24'h1d1212, 24'h1d2424, 24'h1d3636,
		24'h1d4848, 24'h1d5a5a, 24'h1d6c6c, 24'h1d7e7e, 24'h1d0101,
		24'h1e5a00
	};

	tx_datapath_config tx_datapath_config_inst (
		.i_clk_sys(clk), .i_rst_n(rst_n), .i_spi_clk(spi_clk), .i_spi_cs_n(spi_cs_n),
		.i_spi_mosi(spi_mosi), .o_spi_miso(spi_miso), .o_spi_miso_oe(spi_miso_oe),
		.i_in_valid(in_valid), .i_in_i(in_i), .i_in_q(in_q), .o_in_ready(in_ready),
		.i_dac_take(dac_take), .o_dac_valid(dac_valid), .o_dac_i(dac_i), .o_dac_q(dac_q)
	);

	spi_host_model spi_host_model_inst (
		.i_clk_sys(clk), .o_spi_clk(spi_clk), .o_spi_cs_n(spi_cs_n), .o_spi_mosi(spi_mosi),
		.i_spi_miso(spi_miso), .i_spi_miso_oe(spi_miso_oe)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : check

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		spi_host_model_inst.xfer({1'b0, a, d}, rd, ok);
	endtask : wr

	task automatic rdchk(input string nm, input logic [6:0] a, input logic [7:0] exp);
		spi_host_model_inst.xfer({1'b1, a, 8'h00}, rd, ok);
		check(nm, rd, exp);
		check({nm, "_oe"}, ok, 1'b1);
	endtask : rdchk

	// Source holds its offer until the block has room
	task automatic push(input logic [15:0] si, input logic [15:0] sq);
		int n;
		n = 0;
		@(negedge clk);
		in_valid = 1'b1;
		in_i = si;
		in_q = sq;
		while (in_ready !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		in_valid = 1'b0;
	endtask : push

	task automatic pop(input string nm, input logic [15:0] ei, input logic [15:0] eq);
		int n;
		n = 0;
		@(negedge clk);
		dac_take = 1'b1;
		@(negedge clk);
		dac_take = 1'b0;
		while (dac_valid !== 1'b1 && n < 4) begin
			@(negedge clk);
			n++;
		end
		check({nm, "_valid"}, dac_valid, 1'b1);
		check({nm, "_i"}, dac_i, ei);
		check({nm, "_q"}, dac_q, eq);
	endtask : pop

	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			fails++;
			results();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		in_valid = 1'b0;
		in_i = 16'h0000;
		in_q = 16'h0000;
		dac_take = 1'b0;
		repeat (6) @(negedge clk);
		check("ready_in_reset", in_ready, 1'b0);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		check("ready_after_reset", in_ready, 1'b1);
		check("oe_idle", spi_miso_oe, 1'b0);
		rdchk("rst_datapath", 7'h1b, 8'he4);
		rdchk("rst_first", 7'h1c, 8'h00);
		rdchk("rst_second", 7'h1d, 8'h00);
		$display("test reset done");
		foreach (rows[k]) begin
			wr(rows[k][22:16], rows[k][15:8]);
			rdchk($sformatf("row%0d", k), rows[k][22:16], rows[k][7:0]);
		end
		$display("test registers done");
		// All stages bypassed now: samples pass exactly
		for (int k = 0; k < 4; k++) begin
			push(16'h1000 + 16'(k), 16'h8000 + 16'(k));
		end
		repeat (2) @(negedge clk);
		check("ready_full", in_ready, 1'b0);
		for (int k = 0; k < 4; k++) begin
			pop($sformatf("bypass%0d", k), 16'h1000 + 16'(k), 16'h8000 + 16'(k));
		end
		seen = 1'b0;
		@(negedge clk);
		dac_take = 1'b1;
		@(negedge clk);
		dac_take = 1'b0;
		repeat (3) begin
			@(negedge clk);
			seen = seen | (dac_valid === 1'b1);
		end
		check("empty_pop", seen, 1'b0);
		$display("test bypass stream done");
		wr(7'h1b, 8'he5);
		push(16'h1234, 16'h5678);
		pop("copy", 16'h1234, 16'h1234);
		$display("test copy done");
		// Second reset in mid-run restores defaults
		@(negedge clk);
		rst_n = 1'b0;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		rdchk("rerst_datapath", 7'h1b, 8'he4);
		rdchk("rerst_first", 7'h1c, 8'h00);
		$display("test second reset done");
		// Oscillator phase known from reset: one step per output sample
		wr(7'h1c, 8'h01);
		wr(7'h1d, 8'h01);
		wr(7'h1b, 8'hc6);
		push(16'h0400, 16'h0200);
		pop("low_side", 16'h0400, 16'hfe00);
		wr(7'h1b, 8'hcc);
		for (int k = 0; k < 4; k++) begin
			push(16'h0400, 16'h0200);
		end
		pop("gain1", 16'hff00, 16'h0200);
		pop("gain2", 16'hfe00, 16'hff00);
		pop("gain3", 16'h0100, 16'hfe00);
		pop("gain0", 16'h0200, 16'h0100);
		$display("test oscillator done");
		// Premodulator flips odd samples; first stage averages with its last sample
		wr(7'h1b, 8'h60);
		wr(7'h1c, 8'h02);
		push(16'h0400, 16'h0200);
		push(16'h0400, 16'h0200);
		pop("first0", 16'hfc00, 16'hfe00);
		pop("first1", 16'h0100, 16'h0300);
		$display("test stages done");
		results();
	end
endmodule : tx_datapath_config_test
